// ---- aldec_decoder.sv ----
// Byte-serial decoder for multiply, divide, adjust, extend, shift and logic opcodes
`timescale 1ns/1ns
module aldec_decoder (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Prefetch queue
  input wire logic [7:0] q_byte,
  input wire logic q_valid,
  output logic q_ready,
  // Datapath state and variant strap
  input wire logic [7:0] count_low_reg,
  input wire logic narrow_bus_pin,
  // Decoded instruction
  output logic dec_valid,
  output aldec_pkg::aldec_class_e dec_class,
  output aldec_pkg::aldec_shift_op_e dec_shift_op,
  output logic dec_wide,
  output logic dec_mem,
  output logic dec_dir,
  output logic [15:0] dec_imm,
  output logic [7:0] dec_count,
  output logic dec_unsupported,
  output logic [aldec_pkg::CW-1:0] cyc_min,
  output logic [aldec_pkg::CW-1:0] cyc_max,
  // Execution in progress
  output logic exec_busy
);

  typedef enum logic [7:0] {
    S_OP = 8'h01,
    S_MODRM = 8'h02,
    S_FIX = 8'h04,
    S_DISP = 8'h08,
    S_IMM = 8'h10,
    S_CNT = 8'h20,
    S_DONE = 8'h40,
    S_WAIT = 8'h80
  } aldec_state_e;

  typedef struct packed {
    aldec_state_e st;
    aldec_pkg::aldec_class_e cls;
    logic [2:0] fld;
    logic w;
    logic sbit;
    logic dbit;
    logic mem;
    logic [1:0] disp_left;
    logic [1:0] imm_left;
    logic imm_hi;
    logic need_cnt;
    logic [7:0] cnt;
    logic [15:0] imm;
    logic unsup;
    logic rdy;
    logic vld;
    logic start;
    logic [aldec_pkg::CW-1:0] cmin;
    logic [aldec_pkg::CW-1:0] cmax;
    logic sync1;
    logic sync2;
  } aldec_dec_s;

  aldec_dec_s r_q;
  aldec_dec_s r_d;
  aldec_tmr_if tif ();

  aldec_cost_timer u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .t(tif.tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic op_is(input logic [7:0] b, input logic [7:0] m,
                                 input logic [7:0] p);
    op_is = ((b & m) == p);
  endfunction

  // Next fetch phase once the addressing byte or a displacement is done
  function automatic aldec_state_e next_phase(input logic [1:0] disp,
                                              input logic [1:0] imm,
                                              input logic cnt);
    if (disp != 2'h0) begin
      next_phase = S_DISP;
    end else if (imm != 2'h0) begin
      next_phase = S_IMM;
    end else if (cnt) begin
      next_phase = S_CNT;
    end else begin
      next_phase = S_DONE;
    end
  endfunction

  // Displacement bytes implied by the mode and register/memory fields
  function automatic logic [1:0] disp_bytes(input logic [7:0] m);
    if (m[aldec_pkg::MOD_HI:aldec_pkg::MOD_LO] == aldec_pkg::MOD_DISP8) begin
      disp_bytes = 2'h1;
    end else if (m[aldec_pkg::MOD_HI:aldec_pkg::MOD_LO] == aldec_pkg::MOD_DISP16) begin
      disp_bytes = 2'h2;
    end else if (m[aldec_pkg::MOD_HI:aldec_pkg::MOD_LO] == 2'h0 &&
                 m[aldec_pkg::RM_HI:aldec_pkg::RM_LO] == aldec_pkg::RM_DIRECT) begin
      disp_bytes = 2'h2;
    end else begin
      disp_bytes = 2'h0;
    end
  endfunction

  function automatic logic [aldec_pkg::CW-1:0] pick(input logic sel,
                                                    input logic [aldec_pkg::CW-1:0] a,
                                                    input logic [aldec_pkg::CW-1:0] b);
    pick = sel ? b : a;
  endfunction

  localparam int CWM = aldec_pkg::CW - 2;

  // Cycle cost as {min, max}; ranges depend on operand values we cannot see
  function automatic logic [2*aldec_pkg::CW-1:0] cost(input aldec_pkg::aldec_class_e c,
                                                      input logic w, input logic mem,
                                                      input logic sb, input logic db,
                                                      input logic [7:0] n,
                                                      input logic narrow);
    logic [aldec_pkg::CW-1:0] lo;
    logic [aldec_pkg::CW-1:0] hi;
    logic [aldec_pkg::CW-1:0] nn;
    aldec_pkg::aldec_xfer_e xf;
    lo = '0;
    hi = '0;
    nn = {1'b0, n};
    xf = aldec_pkg::ALDEC_XF_NONE;
    case (c)
      aldec_pkg::ALDEC_SIGNED_MUL: begin
        lo = mem ? (w ? 9'd40 : 9'd31) : (w ? 9'd34 : 9'd25);
        hi = mem ? (w ? 9'd43 : 9'd34) : (w ? 9'd37 : 9'd28);
        xf = aldec_pkg::ALDEC_XF_ONE;
      end
      aldec_pkg::ALDEC_SIGNED_IMM_MUL: begin
        lo = pick(sb, 9'd29, 9'd22);
        hi = pick(sb, 9'd32, 9'd25);
      end
      aldec_pkg::ALDEC_UNSIGNED_DIV: begin
        lo = mem ? (w ? 9'd44 : 9'd35) : (w ? 9'd38 : 9'd29);
        hi = lo;
        xf = aldec_pkg::ALDEC_XF_ONE;
      end
      aldec_pkg::ALDEC_SIGNED_DIV: begin
        lo = mem ? (w ? 9'd59 : 9'd50) : (w ? 9'd53 : 9'd44);
        hi = lo + 9'd8;
        xf = aldec_pkg::ALDEC_XF_ONE;
      end
      aldec_pkg::ALDEC_DEC_ADJ_MUL: begin
        lo = aldec_pkg::ADJ_MUL_CYC;
        hi = lo;
      end
      aldec_pkg::ALDEC_DEC_ADJ_DIV: begin
        lo = aldec_pkg::ADJ_DIV_CYC;
        hi = lo;
      end
      aldec_pkg::ALDEC_BYTE_TO_WORD: begin
        lo = aldec_pkg::BYTE_EXT_CYC;
        hi = lo;
      end
      aldec_pkg::ALDEC_WORD_TO_DWORD: begin
        lo = aldec_pkg::WORD_EXT_CYC;
        hi = lo;
      end
      aldec_pkg::ALDEC_SHIFT_ONE: begin
        lo = pick(mem, aldec_pkg::SH_ONE_REG, aldec_pkg::SH_ONE_MEM);
        hi = lo;
      end
      aldec_pkg::ALDEC_SHIFT_CNT_REG, aldec_pkg::ALDEC_SHIFT_IMM: begin
        lo = pick(mem, aldec_pkg::SH_N_REG, aldec_pkg::SH_N_MEM) + nn;
        hi = lo;
      end
      aldec_pkg::ALDEC_AND_RM, aldec_pkg::ALDEC_OR_RM: begin
        lo = pick(mem, 9'd3, 9'd10);
        hi = lo;
        xf = db ? aldec_pkg::ALDEC_XF_ONE : aldec_pkg::ALDEC_XF_TWO;
      end
      aldec_pkg::ALDEC_AND_IMM, aldec_pkg::ALDEC_OR_IMM: begin
        lo = pick(mem, 9'd4, 9'd16);
        hi = lo;
        xf = aldec_pkg::ALDEC_XF_TWO;
      end
      aldec_pkg::ALDEC_TEST_RM: begin
        lo = pick(mem, 9'd3, 9'd10);
        hi = lo;
        xf = aldec_pkg::ALDEC_XF_ONE;
      end
      aldec_pkg::ALDEC_TEST_IMM: begin
        lo = pick(mem, 9'd4, 9'd10);
        hi = lo;
        xf = aldec_pkg::ALDEC_XF_ONE;
      end
      aldec_pkg::ALDEC_AND_ACC, aldec_pkg::ALDEC_TEST_ACC, aldec_pkg::ALDEC_OR_ACC: begin
        lo = pick(w, 9'd3, 9'd4);
        hi = lo;
      end
      default: begin
        lo = '0;
        hi = '0;
      end
    endcase
    if (narrow && w && mem && xf != aldec_pkg::ALDEC_XF_NONE) begin
      lo = lo + ((xf == aldec_pkg::ALDEC_XF_TWO) ? {aldec_pkg::NARROW_ADD[CWM:0], 1'b0}
                                                 : aldec_pkg::NARROW_ADD);
      hi = hi + ((xf == aldec_pkg::ALDEC_XF_TWO) ? {aldec_pkg::NARROW_ADD[CWM:0], 1'b0}
                                                 : aldec_pkg::NARROW_ADD);
    end
    cost = {lo, hi};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode sequencer

  always_comb begin
    logic take;
    logic [7:0] b;
    logic [2*aldec_pkg::CW-1:0] cc;
    take = q_valid && r_q.rdy;
    b = q_byte;
    cc = '0;
    r_d = r_q;
    r_d.vld = 1'b0;
    r_d.start = 1'b0;
    r_d.sync1 = narrow_bus_pin;
    r_d.sync2 = r_q.sync1;
    case (r_q.st)
      S_OP: begin
        if (take) begin
          r_d.w = b[aldec_pkg::BIT_W];
          r_d.dbit = b[aldec_pkg::BIT_D];
          r_d.sbit = b[aldec_pkg::BIT_S];
          r_d.mem = 1'b0;
          r_d.unsup = 1'b0;
          r_d.imm = '0;
          r_d.cnt = '0;
          r_d.fld = '0;
          r_d.imm_left = 2'h0;
          r_d.need_cnt = 1'b0;
          r_d.st = S_MODRM;
          if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_GRP3)) begin
            r_d.cls = aldec_pkg::ALDEC_NONE;
          end else if (op_is(b, aldec_pkg::MASK_S, aldec_pkg::OPC_SIGNED_MUL_IMM)) begin
            r_d.cls = aldec_pkg::ALDEC_SIGNED_IMM_MUL;
            r_d.w = 1'b1;
            r_d.imm_left = b[aldec_pkg::BIT_S] ? 2'h1 : 2'h2;
          end else if (b == aldec_pkg::OPC_ADJ_MUL) begin
            r_d.cls = aldec_pkg::ALDEC_DEC_ADJ_MUL;
            r_d.st = S_FIX;
          end else if (b == aldec_pkg::OPC_ADJ_DIV) begin
            r_d.cls = aldec_pkg::ALDEC_DEC_ADJ_DIV;
            r_d.st = S_FIX;
          end else if (b == aldec_pkg::OPC_BYTE_EXT) begin
            r_d.cls = aldec_pkg::ALDEC_BYTE_TO_WORD;
            r_d.st = S_DONE;
          end else if (b == aldec_pkg::OPC_WORD_EXT) begin
            r_d.cls = aldec_pkg::ALDEC_WORD_TO_DWORD;
            r_d.st = S_DONE;
          end else if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_SH_ONE)) begin
            r_d.cls = aldec_pkg::ALDEC_SHIFT_ONE;
          end else if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_SH_CNT_REG)) begin
            r_d.cls = aldec_pkg::ALDEC_SHIFT_CNT_REG;
          end else if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_SH_IMM)) begin
            r_d.cls = aldec_pkg::ALDEC_SHIFT_IMM;
            r_d.need_cnt = 1'b1;
          end else if (op_is(b, aldec_pkg::MASK_DW, aldec_pkg::OPC_AND_RM)) begin
            r_d.cls = aldec_pkg::ALDEC_AND_RM;
          end else if (op_is(b, aldec_pkg::MASK_DW, aldec_pkg::OPC_OR_RM)) begin
            r_d.cls = aldec_pkg::ALDEC_OR_RM;
          end else if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_TEST_RM)) begin
            r_d.cls = aldec_pkg::ALDEC_TEST_RM;
          end else if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_GRP1)) begin
            r_d.cls = aldec_pkg::ALDEC_NONE;
            r_d.imm_left = b[aldec_pkg::BIT_W] ? 2'h2 : 2'h1;
          end else if (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_AND_ACC) ||
                       op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_TEST_ACC) ||
                       op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_OR_ACC)) begin
            r_d.cls = op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_AND_ACC) ?
                      aldec_pkg::ALDEC_AND_ACC :
                      (op_is(b, aldec_pkg::MASK_W, aldec_pkg::OPC_OR_ACC) ?
                       aldec_pkg::ALDEC_OR_ACC : aldec_pkg::ALDEC_TEST_ACC);
            r_d.imm_left = b[aldec_pkg::BIT_W] ? 2'h2 : 2'h1;
            r_d.st = S_IMM;
          end else begin
            // Length unknown outside this group, so report and stay on opcodes
            r_d.cls = aldec_pkg::ALDEC_NONE;
            r_d.unsup = 1'b1;
            r_d.st = S_DONE;
          end
        end
      end
      S_MODRM: begin
        if (take) begin
          r_d.fld = b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO];
          r_d.mem = (b[aldec_pkg::MOD_HI:aldec_pkg::MOD_LO] != aldec_pkg::MOD_REG);
          r_d.disp_left = disp_bytes(b);
          if (r_q.cls == aldec_pkg::ALDEC_NONE && r_q.imm_left != 2'h0) begin
            if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::FLD_AND) begin
              r_d.cls = aldec_pkg::ALDEC_AND_IMM;
            end else if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::FLD_OR) begin
              r_d.cls = aldec_pkg::ALDEC_OR_IMM;
            end else begin
              r_d.unsup = 1'b1;
            end
          end else if (r_q.cls == aldec_pkg::ALDEC_NONE) begin
            if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::FLD_SMUL) begin
              r_d.cls = aldec_pkg::ALDEC_SIGNED_MUL;
            end else if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::FLD_UDIV) begin
              r_d.cls = aldec_pkg::ALDEC_UNSIGNED_DIV;
            end else if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::FLD_SDIV) begin
              r_d.cls = aldec_pkg::ALDEC_SIGNED_DIV;
            end else if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::FLD_TEST) begin
              r_d.cls = aldec_pkg::ALDEC_TEST_IMM;
              r_d.imm_left = r_q.w ? 2'h2 : 2'h1;
            end else begin
              r_d.unsup = 1'b1;
            end
          end else if (r_q.cls == aldec_pkg::ALDEC_SHIFT_ONE ||
                       r_q.cls == aldec_pkg::ALDEC_SHIFT_CNT_REG ||
                       r_q.cls == aldec_pkg::ALDEC_SHIFT_IMM) begin
            if (b[aldec_pkg::FLD_HI:aldec_pkg::FLD_LO] == aldec_pkg::ALDEC_SHIFT_UNDEF) begin
              r_d.unsup = 1'b1;
            end
          end
          if (r_q.cls == aldec_pkg::ALDEC_SHIFT_CNT_REG) begin
            r_d.cnt = count_low_reg;
          end
          r_d.st = next_phase(r_d.disp_left, r_d.imm_left, r_q.need_cnt);
        end
      end
      S_FIX: begin
        if (take) begin
          r_d.unsup = (b != aldec_pkg::OPC_ADJ_BASE);
          r_d.st = S_DONE;
        end
      end
      S_DISP: begin
        if (take) begin
          r_d.disp_left = r_q.disp_left - 2'h1;
          r_d.st = next_phase(r_d.disp_left, r_q.imm_left, r_q.need_cnt);
        end
      end
      S_IMM: begin
        if (take) begin
          // Low byte first, high byte second
          if (r_q.imm_left == 2'h2) begin
            r_d.imm[7:0] = b;
          end else if (r_q.imm_hi) begin
            r_d.imm[15:8] = b;
          end else begin
            r_d.imm[7:0] = b;
          end
          r_d.imm_hi = (r_q.imm_left == 2'h2);
          r_d.imm_left = r_q.imm_left - 2'h1;
          r_d.st = next_phase(2'h0, r_d.imm_left, r_q.need_cnt);
        end
      end
      S_CNT: begin
        if (take) begin
          r_d.cnt = b;
          r_d.need_cnt = 1'b0;
          r_d.st = S_DONE;
        end
      end
      S_DONE: begin
        cc = cost(r_q.cls, r_q.w, r_q.mem, r_q.sbit, r_q.dbit, r_q.cnt, r_q.sync2);
        r_d.cmin = r_q.unsup ? '0 : cc[2*aldec_pkg::CW-1:aldec_pkg::CW];
        r_d.cmax = r_q.unsup ? '0 : cc[aldec_pkg::CW-1:0];
        r_d.imm_hi = 1'b0;
        r_d.vld = 1'b1;
        r_d.start = 1'b1;
        r_d.st = S_WAIT;
      end
      S_WAIT: begin
        // Timer answers a cycle after start, so start itself also blocks
        if (!r_q.start && !tif.busy) begin
          r_d.st = S_OP;
        end
      end
      default: begin
        r_d.st = S_OP;
      end
    endcase
    r_d.rdy = (r_d.st == S_OP) || (r_d.st == S_MODRM) || (r_d.st == S_FIX) ||
              (r_d.st == S_DISP) || (r_d.st == S_IMM) || (r_d.st == S_CNT);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_q <= '{st: S_OP, cls: aldec_pkg::ALDEC_NONE, rdy: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign tif.start = r_q.start;
  assign tif.load = r_q.cmin;
  assign q_ready = r_q.rdy;
  assign dec_valid = r_q.vld;
  assign dec_class = r_q.cls;
  assign dec_shift_op = aldec_pkg::aldec_shift_op_e'(r_q.fld);
  assign dec_wide = r_q.w;
  assign dec_mem = r_q.mem;
  assign dec_dir = r_q.dbit;
  assign dec_imm = r_q.imm;
  assign dec_count = r_q.cnt;
  assign dec_unsupported = r_q.unsup;
  assign cyc_min = r_q.cmin;
  assign cyc_max = r_q.cmax;
  assign exec_busy = tif.busy;

endmodule

// ---- aldec_pkg.sv ----
// Constants, types and cycle costs for the arithmetic and logic opcode decoder
// Function
// - Group-three field 101 is signed_mul; 25-28 byte, 34-37 word register cycles.
// - 011010s1 is signed_imm_mul; s=0 adds an immediate byte; 22-25 or 29-32.
// - Group-three field 110 is unsigned_div: 29, 38, 35, 44 cycles.
// - Group-three field 111 is signed_div: 44-52, 53-61, 50-58, 59-67 cycles.
// - Bytes 11010100 then 00001010 are decimal_adjust_mul, 19 cycles.
// - Bytes 11010101 then 00001010 are decimal_adjust_div, 15 cycles.
// - 10011000 is byte_to_word_extend, 2 cycles.
// - 10011001 is word_to_dword_extend, 4 cycles.
// - 1101000w shifts or rotates by one: 2 register, 15 memory cycles.
// - 1101001w shifts by count_low_reg: 5+n register, 17+n memory cycles.
// - 1100000w shifts by an immediate count byte after the addressing byte.
// - conjunction_op: 001000dw 3/10, group-one field 100 4/16, 0010010w accumulator.
// - flag_probe_op: 1000010w 3/10, group-three 000 4/10, 1010100w 3/4.
// - disjunction_op: 000010dw, group-one field 001, 0000110w accumulator 3/4.
// - Accumulator immediates fetch one byte, and a second only when w is 1.
// - Narrow-bus variant adds 4 cycles per memory transfer for word operations other than shifts and signed_imm_mul.
package aldec_pkg;

  // Opcode patterns and masks
  localparam logic [7:0] MASK_W = 8'hFE;
  localparam logic [7:0] MASK_DW = 8'hFC;
  localparam logic [7:0] MASK_S = 8'hFD;
  localparam logic [7:0] OPC_GRP3 = 8'hF6;
  localparam logic [7:0] OPC_SIGNED_MUL_IMM = 8'h69;
  localparam logic [7:0] OPC_ADJ_MUL = 8'hD4;
  localparam logic [7:0] OPC_ADJ_DIV = 8'hD5;
  localparam logic [7:0] OPC_ADJ_BASE = 8'h0A;
  localparam logic [7:0] OPC_BYTE_EXT = 8'h98;
  localparam logic [7:0] OPC_WORD_EXT = 8'h99;
  localparam logic [7:0] OPC_SH_ONE = 8'hD0;
  localparam logic [7:0] OPC_SH_CNT_REG = 8'hD2;
  localparam logic [7:0] OPC_SH_IMM = 8'hC0;
  localparam logic [7:0] OPC_AND_RM = 8'h20;
  localparam logic [7:0] OPC_GRP1 = 8'h80;
  localparam logic [7:0] OPC_AND_ACC = 8'h24;
  localparam logic [7:0] OPC_TEST_RM = 8'h84;
  localparam logic [7:0] OPC_TEST_ACC = 8'hA8;
  localparam logic [7:0] OPC_OR_RM = 8'h08;
  localparam logic [7:0] OPC_OR_ACC = 8'h0C;

  // Opcode bit positions
  localparam int BIT_W = 0;
  localparam int BIT_D = 1;
  localparam int BIT_S = 1;

  // Addressing byte layout
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int FLD_HI = 5;
  localparam int FLD_LO = 3;
  localparam int RM_HI = 2;
  localparam int RM_LO = 0;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // Operation field codes of the immediate groups
  localparam logic [2:0] FLD_TEST = 3'h0;
  localparam logic [2:0] FLD_OR = 3'h1;
  localparam logic [2:0] FLD_AND = 3'h4;
  localparam logic [2:0] FLD_SMUL = 3'h5;
  localparam logic [2:0] FLD_UDIV = 3'h6;
  localparam logic [2:0] FLD_SDIV = 3'h7;

  // Cycle figures
  localparam int CW = 9;
  localparam logic [CW-1:0] NARROW_ADD = 9'h004;
  localparam logic [CW-1:0] SH_ONE_REG = 9'h002;
  localparam logic [CW-1:0] SH_ONE_MEM = 9'h00F;
  localparam logic [CW-1:0] SH_N_REG = 9'h005;
  localparam logic [CW-1:0] SH_N_MEM = 9'h011;
  localparam logic [CW-1:0] ADJ_MUL_CYC = 9'h013;
  localparam logic [CW-1:0] ADJ_DIV_CYC = 9'h00F;
  localparam logic [CW-1:0] BYTE_EXT_CYC = 9'h002;
  localparam logic [CW-1:0] WORD_EXT_CYC = 9'h004;

  typedef enum logic [1:0] {
    ALDEC_XF_NONE = 2'h0,
    ALDEC_XF_ONE = 2'h1,
    ALDEC_XF_TWO = 2'h2
  } aldec_xfer_e;

  typedef enum logic [4:0] {
    ALDEC_NONE = 5'h00,
    ALDEC_SIGNED_MUL = 5'h01,
    ALDEC_SIGNED_IMM_MUL = 5'h02,
    ALDEC_UNSIGNED_DIV = 5'h03,
    ALDEC_SIGNED_DIV = 5'h04,
    ALDEC_DEC_ADJ_MUL = 5'h05,
    ALDEC_DEC_ADJ_DIV = 5'h06,
    ALDEC_BYTE_TO_WORD = 5'h07,
    ALDEC_WORD_TO_DWORD = 5'h08,
    ALDEC_SHIFT_ONE = 5'h09,
    ALDEC_SHIFT_CNT_REG = 5'h0A,
    ALDEC_SHIFT_IMM = 5'h0B,
    ALDEC_AND_RM = 5'h0C,
    ALDEC_AND_IMM = 5'h0D,
    ALDEC_AND_ACC = 5'h0E,
    ALDEC_TEST_RM = 5'h0F,
    ALDEC_TEST_IMM = 5'h10,
    ALDEC_TEST_ACC = 5'h11,
    ALDEC_OR_RM = 5'h12,
    ALDEC_OR_IMM = 5'h13,
    ALDEC_OR_ACC = 5'h14
  } aldec_class_e;

  typedef enum logic [2:0] {
    ALDEC_ROTATE_LEFT = 3'h0,
    ALDEC_ROTATE_RIGHT = 3'h1,
    ALDEC_ROTATE_CARRY_LEFT = 3'h2,
    ALDEC_ROTATE_CARRY_RIGHT = 3'h3,
    ALDEC_SHIFT_LEFT = 3'h4,
    ALDEC_LOGICAL_SHIFT_RIGHT = 3'h5,
    ALDEC_SHIFT_UNDEF = 3'h6,
    ALDEC_ARITH_SHIFT_RIGHT = 3'h7
  } aldec_shift_op_e;

endpackage

// ---- aldec_tmr_if.sv ----
// Start and busy handshake between the decoder and its execution-cost timer
`timescale 1ns/1ns
interface aldec_tmr_if;
  logic start;
  logic [aldec_pkg::CW-1:0] load;
  logic busy;
  modport dec (output start, output load, input busy);
  modport tmr (input start, input load, output busy);
endinterface

// ---- aldec_cost_timer.sv ----
// Down counter that holds the decoder busy for an instruction's minimum cycle cost
`timescale 1ns/1ns
module aldec_cost_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Decoder side
  aldec_tmr_if.tmr t
);

  typedef struct packed {
    logic [aldec_pkg::CW-1:0] left;
    logic busy;
  } aldec_tmr_s;

  aldec_tmr_s r_q;
  aldec_tmr_s r_d;

  always_comb begin
    r_d = r_q;
    if (t.start && (t.load != '0)) begin
      r_d.left = t.load;
      r_d.busy = 1'b1;
    end else if (r_q.busy) begin
      r_d.left = r_q.left - 1'b1;
      r_d.busy = (r_q.left > 9'h001);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign t.busy = r_q.busy;

endmodule

// ---- aldec_monitor.sv ----
// Port checks on the opcode decoder: costs and timer handshake
`timescale 1ns/1ns
module aldec_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Observed outputs
  input wire logic q_ready,
  input wire logic dec_valid,
  input wire aldec_pkg::aldec_class_e dec_class,
  input wire logic dec_wide,
  input wire logic dec_mem,
  input wire logic [7:0] dec_count,
  input wire logic dec_unsupported,
  input wire logic [aldec_pkg::CW-1:0] cyc_min,
  input wire logic [aldec_pkg::CW-1:0] cyc_max,
  input wire logic exec_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire ok = dec_valid && !dec_unsupported;
  sequence busy_two; ##1 exec_busy [*2] ##1 !exec_busy; endsequence
  sequence busy_four; ##1 exec_busy [*4] ##1 !exec_busy; endsequence
  sequence ready_back; !q_ready ##1 q_ready; endsequence
  //////////////////////////////////////////////////////////////////////////////
  byte_ext_a: assert property (ok && dec_class == aldec_pkg::ALDEC_BYTE_TO_WORD
    |-> cyc_min == 9'h002 && cyc_max == 9'h002 ##0 busy_two ##0 ready_back)
    else $error("byte extend cost");
  word_ext_a: assert property (ok && dec_class == aldec_pkg::ALDEC_WORD_TO_DWORD
    |-> cyc_min == 9'h004 && cyc_max == 9'h004 ##0 busy_four) else $error("word extend cost");
  adj_mul_a: assert property (ok && dec_class == aldec_pkg::ALDEC_DEC_ADJ_MUL
    |-> cyc_min == 9'h013 && cyc_max == 9'h013) else $error("adjust mul cost");
  adj_div_a: assert property (ok && dec_class == aldec_pkg::ALDEC_DEC_ADJ_DIV
    |-> cyc_min == 9'h00F && cyc_max == 9'h00F) else $error("adjust div cost");
  udiv_reg_a: assert property (ok && dec_class == aldec_pkg::ALDEC_UNSIGNED_DIV && !dec_mem
    |-> cyc_min == (dec_wide ? 9'h026 : 9'h01D)) else $error("udiv cost");
  sdiv_reg_a: assert property (ok && dec_class == aldec_pkg::ALDEC_SIGNED_DIV && !dec_mem
    |-> cyc_max == (dec_wide ? 9'h03D : 9'h034)) else $error("sdiv cost");
  smul_reg_a: assert property (ok && dec_class == aldec_pkg::ALDEC_SIGNED_MUL && !dec_mem
    |-> cyc_min == (dec_wide ? 9'h022 : 9'h019)) else $error("smul cost");
  shift_cnt_a: assert property (ok && dec_class == aldec_pkg::ALDEC_SHIFT_CNT_REG && !dec_mem
    |-> cyc_min == 9'(dec_count) + 9'h005) else $error("shift count cost");
  shift_one_a: assert property (ok && dec_class == aldec_pkg::ALDEC_SHIFT_ONE
    |-> cyc_min == (dec_mem ? 9'h00F : 9'h002)) else $error("shift one cost");
endmodule
bind aldec_decoder aldec_monitor i_mon (.sys_clk, .rst, .q_ready, .dec_valid, .dec_class,
  .dec_wide, .dec_mem, .dec_count, .dec_unsupported, .cyc_min, .cyc_max, .exec_busy);

// ---- tb_top.sv ----
// Self-checking bench for the opcode decoder
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] q_byte = 8'h00;
  logic q_valid = 1'b0;
  logic [7:0] count_low_reg = 8'h00;
  logic narrow_bus_pin = 1'b0;
  logic q_ready, dec_valid, dec_wide, dec_mem, dec_dir, dec_unsupported, exec_busy;
  aldec_pkg::aldec_class_e dec_class;
  aldec_pkg::aldec_shift_op_e dec_shift_op;
  logic [15:0] dec_imm;
  logic [7:0] dec_count, n;
  logic [aldec_pkg::CW-1:0] cyc_min, cyc_max;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h00014C90;
  aldec_decoder i_dut (.sys_clk, .rst, .q_byte, .q_valid, .q_ready, .count_low_reg,
    .narrow_bus_pin, .dec_valid, .dec_class, .dec_shift_op, .dec_wide, .dec_mem,
    .dec_dir, .dec_imm, .dec_count, .dec_unsupported, .cyc_min, .cyc_max, .exec_busy);
  always #50 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0] & 8'h1F;
  endfunction
  function automatic logic [8:0] shc(input logic mem, input logic [7:0] k);
    return (mem ? 9'h011 : 9'h005) + 9'(k);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [7:0] b);
    q_byte <= b;
    q_valid <= 1'b1;
    @(negedge sys_clk);
    repeat (300) if (q_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // Class FFFF stands for an expected refusal of the opcode
  task automatic run(input logic [23:0] b, input int len, input logic [15:0] c,
                     input logic [8:0] mn, input logic [8:0] mx);
    @(posedge sys_clk);
    for (int i = 0; i < len; i++) put(b[23-8*i -: 8]);
    q_valid <= 1'b0;
    @(negedge sys_clk);
    repeat (8) if (dec_valid !== 1'b1) @(negedge sys_clk);
    chk("valid", 16'h0001, {15'h0000, dec_valid});
    if (c == 16'hFFFF) chk("unsup", 16'h0001, {15'h0000, dec_unsupported});
    else chk("class", c, 16'(dec_class));
    chk("cyc_min", 16'(mn), 16'(cyc_min));
    chk("cyc_max", 16'(mx), 16'(cyc_max));
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    run(24'h980000, 1, aldec_pkg::ALDEC_BYTE_TO_WORD, 2, 2);
    run(24'h990000, 1, aldec_pkg::ALDEC_WORD_TO_DWORD, 4, 4);
    run(24'hD40A00, 2, aldec_pkg::ALDEC_DEC_ADJ_MUL, 19, 19);
    run(24'hD50A00, 2, aldec_pkg::ALDEC_DEC_ADJ_DIV, 15, 15);
    run(24'hD40B00, 2, 16'hFFFF, 0, 0);
    run(24'hF6E800, 2, aldec_pkg::ALDEC_SIGNED_MUL, 25, 28);
    run(24'hF7F000, 2, aldec_pkg::ALDEC_UNSIGNED_DIV, 38, 38);
    run(24'hF6F800, 2, aldec_pkg::ALDEC_SIGNED_DIV, 44, 52);
    run(24'hF7F800, 2, aldec_pkg::ALDEC_SIGNED_DIV, 53, 61);
    run(24'hD10000, 2, aldec_pkg::ALDEC_SHIFT_ONE, 15, 15);
    run(24'hD0F000, 2, 16'hFFFF, 0, 0);
    run(24'h6BC005, 3, aldec_pkg::ALDEC_SIGNED_IMM_MUL, 22, 25);
    run(24'h250134, 3, aldec_pkg::ALDEC_AND_ACC, 4, 4);
    chk("imm", 16'h3401, dec_imm);
    run(24'hA87F00, 2, aldec_pkg::ALDEC_TEST_ACC, 3, 3);
    chk("imm", 16'h007F, dec_imm);
    run(24'h0C5500, 2, aldec_pkg::ALDEC_OR_ACC, 3, 3);
    run(24'h80E15A, 3, aldec_pkg::ALDEC_AND_IMM, 4, 4);
    chk("imm", 16'h005A, dec_imm);
    run(24'h800833, 3, aldec_pkg::ALDEC_OR_IMM, 16, 16);
    run(24'hF6C012, 3, aldec_pkg::ALDEC_TEST_IMM, 4, 4);
    run(24'h0AC100, 2, aldec_pkg::ALDEC_OR_RM, 3, 3);
    chk("dir", 16'h0001, {15'h0000, dec_dir});
    run(24'h210700, 2, aldec_pkg::ALDEC_AND_RM, 10, 10);
    chk("dir", 16'h0000, {15'h0000, dec_dir});
    for (int f = 0; f < 8; f++) if (f != 6) begin
      n = xs();
      @(posedge sys_clk);
      count_low_reg <= n;
      run({8'hD2, 2'b11, 3'(f), 11'h100}, 2, aldec_pkg::ALDEC_SHIFT_CNT_REG, shc(0, n), shc(0, n));
      chk("op", 16'(f), 16'(dec_shift_op));
      run({16'hC020, n}, 3, aldec_pkg::ALDEC_SHIFT_IMM, shc(1, n), shc(1, n));
    end
    @(posedge sys_clk);
    narrow_bus_pin <= 1'b1;
    run(24'h850700, 2, aldec_pkg::ALDEC_TEST_RM, 14, 14);
    run(24'h210700, 2, aldec_pkg::ALDEC_AND_RM, 18, 18);
    run(24'hF72F00, 2, aldec_pkg::ALDEC_SIGNED_MUL, 44, 47);
    run(24'h85C100, 2, aldec_pkg::ALDEC_TEST_RM, 3, 3);
    give_verdict();
  end
  initial begin
    #(100 * 20000);
    n_mismatch++;
    give_verdict();
  end
endmodule
